// ---- rtl/cav_pkg.sv ----
// Purpose: Shared constants and carrier types for the addressing and vectoring block
// Assumes: Byte-wide special-register bus, one system clock
// Notes: Offsets are special-register addresses
package cav_pkg;
	// Register offsets
	localparam logic [7:0] CAV_OFS_SP_LOW = 8'h81;
	localparam logic [7:0] CAV_OFS_P0_LOW = 8'h82;
	localparam logic [7:0] CAV_OFS_P0_HIGH = 8'h83;
	localparam logic [7:0] CAV_OFS_P1_LOW = 8'h84;
	localparam logic [7:0] CAV_OFS_P1_HIGH = 8'h85;
	localparam logic [7:0] CAV_OFS_PSEL = 8'h86;
	localparam logic [7:0] CAV_OFS_WAIT = 8'h92;
	localparam logic [7:0] CAV_OFS_P0_TOP = 8'h93;
	localparam logic [7:0] CAV_OFS_P1_TOP = 8'h95;
	localparam logic [7:0] CAV_OFS_SP_HIGH = 8'h9b;
	localparam logic [7:0] CAV_OFS_AMODE = 8'h9d;
	localparam logic [7:0] CAV_OFS_STATUS = 8'hc5;
	localparam logic [7:0] CAV_OFS_XBASE = 8'hc6;
	localparam logic [7:0] CAV_OFS_TICKET = 8'hc7;
	localparam logic [7:0] CAV_OFS_RI_PAGE = 8'hda;
	localparam logic [7:0] CAV_OFS_RI_TOP = 8'hea;
	// Reset values
	localparam logic [7:0] CAV_RST_ZERO = 8'h00;
	localparam logic [3:0] CAV_RST_WAIT = 4'h7;
	// Field positions
	localparam int CAV_STAT_HIGH_BIT = 6;
	localparam int CAV_STAT_LOW_BIT = 5;
	localparam int CAV_AM_RELOC_BIT = 5;
	localparam int CAV_AM_RIPAGE_BIT = 3;
	localparam int CAV_AM_XSTACK_BIT = 2;
	localparam int CAV_AM_WIDE_BIT = 1;
	localparam int CAV_AM_LOW_BIT = 0;
	localparam int CAV_PS_DIR1_BIT = 7;
	localparam int CAV_PS_DIR0_BIT = 6;
	localparam int CAV_PS_TOGGLE_BIT = 5;
	localparam int CAV_PS_SEL_BIT = 0;
	// Ticket sequence
	localparam logic [7:0] CAV_TICKET_FIRST = 8'haa;
	localparam logic [7:0] CAV_TICKET_SECOND = 8'h55;
	// Interrupt sources and vectors
	localparam int CAV_IRQ_NUM = 15;
	localparam int CAV_IRQ_TIMER0 = 1;
	localparam int CAV_IRQ_TIMER1 = 3;
	localparam logic [15:0] CAV_VEC_FIRST = 16'h0003;
	localparam int CAV_VEC_STEP_SHIFT = 3;
	localparam logic [15:0] CAV_VEC_BKPT = 16'h0080;
	localparam logic [15:0] CAV_VEC_DEBUG = 16'h00c0;
	localparam logic [3:0] CAV_VEC_TOP_NIBBLE = 4'hf;
	// Ticket states
	typedef enum logic [2:0] {
		CAV_TK_IDLE = 3'b001,
		CAV_TK_ARMED = 3'b010,
		CAV_TK_OPEN = 3'b100
	} cav_ticket_t;
	// Arbitration classes
	typedef enum logic [2:0] {
		CAV_LVL_LOW = 3'b001,
		CAV_LVL_HIGH = 3'b010,
		CAV_LVL_DEBUG = 3'b100
	} cav_level_t;
	// Stack RAM access
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic we;
		logic re;
	} cav_stk_t;
	// Arbitration winner
	typedef struct packed {
		logic valid;
		logic [15:0] vec;
		logic [3:0] idx;
		logic dbg;
		logic breakpoint_irq;
		cav_level_t level;
	} cav_win_t;
endpackage

// ---- rtl/cav_ptr_step.sv ----
// Purpose: One step of a data pointer, up or down
// Assumes: Pointer is top:high:low, 24 bits
// Notes: Top byte joins the carry only in wide mode
`timescale 1ns/1ps
`default_nettype none
module cav_ptr_step import cav_pkg::*; (
	input wire logic [23:0] ptr_i,
	input wire logic dec_i,
	input wire logic wide_i,
	output logic [23:0] ptr_o
);
	logic [23:0] full;
	logic [15:0] low16;

	// Compute both widths, then pick; compatible mode keeps the top byte
	always_comb begin
		full = dec_i ? ptr_i - 24'h000001 : ptr_i + 24'h000001;
		low16 = dec_i ? ptr_i[15:0] - 16'h0001 : ptr_i[15:0] + 16'h0001;
		ptr_o = wide_i ? full : {ptr_i[23:16], low16};
	end
endmodule
`default_nettype wire

// ---- rtl/cav_irq_arb.sv ----
// Purpose: Two-level priority resolution with two debug-class sources on top
// Assumes: Requests are already sampled and held by the caller
// Notes: Purely combinational; the caller registers what it needs
`timescale 1ns/1ps
`default_nettype none
module cav_irq_arb import cav_pkg::*; #(
	parameter int NUM = CAV_IRQ_NUM
) (
	input wire logic [NUM-1:0] pend_i,
	input wire logic [NUM-1:0] en_i,
	input wire logic [NUM-1:0] high_i,
	input wire logic global_en_i,
	input wire logic bkp_i,
	input wire logic dbg_i,
	input wire logic [2:0] active_i,
	input wire logic [15:0] base_i,
	output cav_win_t win_o
);
	logic [NUM-1:0] live;
	logic [NUM-1:0] hi_req;
	logic [NUM-1:0] lo_req;
	logic [3:0] hi_idx;
	logic [3:0] lo_idx;
	logic blk_dbg;
	logic blk_high;
	logic blk_low;

	assign live = pend_i & en_i & {NUM{global_en_i}};
	assign hi_req = live & high_i;
	assign lo_req = live & ~high_i;
	// Nesting: a service blocks its own and lower levels
	assign blk_dbg = active_i[2];
	assign blk_high = active_i[2] | active_i[1];
	assign blk_low = |active_i;

	// Lowest index wins inside a level; scan downward so the last hit stays
	always_comb begin
		hi_idx = 4'h0;
		lo_idx = 4'h0;
		for (int i = NUM - 1; i >= 0; i--) begin
			if (hi_req[i]) begin
				hi_idx = 4'(i);
			end
			if (lo_req[i]) begin
				lo_idx = 4'(i);
			end
		end
	end

	// Debug over breakpoint over high over low; debug pair ignores the global enable
	always_comb begin
		win_o = '0;
		win_o.level = CAV_LVL_LOW;
		if ((dbg_i | bkp_i) && !blk_dbg) begin
			win_o.valid = 1'b1;
			win_o.dbg = dbg_i;
			win_o.breakpoint_irq = !dbg_i;
			win_o.level = CAV_LVL_DEBUG;
			win_o.vec = base_i | (dbg_i ? CAV_VEC_DEBUG : CAV_VEC_BKPT);
		end else if (|hi_req && !blk_high) begin
			win_o.valid = 1'b1;
			win_o.idx = hi_idx;
			win_o.level = CAV_LVL_HIGH;
			win_o.vec = base_i | (CAV_VEC_FIRST + (16'(hi_idx) << CAV_VEC_STEP_SHIFT));
		end else if (|lo_req && !blk_low) begin
			win_o.valid = 1'b1;
			win_o.idx = lo_idx;
			win_o.vec = base_i | (CAV_VEC_FIRST + (16'(lo_idx) << CAV_VEC_STEP_SHIFT));
		end
	end
endmodule
`default_nettype wire

// ---- rtl/cav_core.sv ----
// Purpose: Stack, addressing modes, wait states, data pointers and interrupt vectoring
// Assumes: All inputs synchronous to REF_CLK_I; CPU strobes are one-cycle pulses
// Notes: Register file sits on the byte-wide special-register bus
`timescale 1ns/1ps
`default_nettype none
module cav_core import cav_pkg::*; #(
	parameter int NUM_IRQ = CAV_IRQ_NUM,
	parameter logic [3:0] TOP_NIBBLE = CAV_VEC_TOP_NIBBLE
) (
	input wire logic REF_CLK_I,
	input wire logic RST_I,
	input wire logic [7:0] SFR_ADDR_I,
	input wire logic SFR_WR_I,
	input wire logic SFR_RD_I,
	input wire logic [7:0] SFR_WDATA_I,
	output logic [7:0] SFR_RDATA_O,
	input wire logic PUSH_I,
	input wire logic POP_I,
	input wire logic [7:0] ACC_I,
	output cav_stk_t STK_O,
	input wire logic FETCH_REQ_I,
	input wire logic [19:0] FETCH_ADDR_I,
	output logic [19:0] FLASH_ADDR_O,
	output logic FETCH_DONE_O,
	input wire logic MOVX_RI_I,
	input wire logic MOVX_DP_I,
	input wire logic [7:0] RI_I,
	input wire logic [7:0] P2_LATCH_I,
	output logic [23:0] XADDR_O,
	output logic XADDR_VLD_O,
	input wire logic PTR_INC_I,
	input wire logic PTR_USE_I,
	input wire logic [NUM_IRQ-1:0] IRQ_FLAG_I,
	input wire logic [NUM_IRQ-1:0] IRQ_EN_I,
	input wire logic [NUM_IRQ-1:0] IRQ_HIGH_I,
	input wire logic GLOBAL_EN_I,
	input wire logic BKPT_MATCH_I,
	input wire logic DBG_PORT_MODE_I,
	input wire logic DBG_MATCH_I,
	input wire logic IRQ_ACK_I,
	input wire logic RETI_I,
	output logic IRQ_REQ_O,
	output logic [15:0] IRQ_VEC_O,
	output logic [1:0] TIMER_CLR_O,
	output logic WIDE_MODE_O
);
	logic [7:0] sp_low_q, sp_high_q;
	logic [23:0] ptr0_q, ptr1_q;
	logic [7:0] psel_q;
	logic [3:0] wait_q;
	logic [7:0] amode_q;
	logic [7:0] xbase_q;
	logic [7:0] ri_page_q, ri_top_q;
	cav_ticket_t tk_q;
	logic prot_ok;
	logic wide;
	logic sel;
	logic [15:0] sp_full, sp_next;
	logic wr_sp_low, wr_sp_high;
	logic [23:0] ptr_cur, ptr_stepped;
	logic ptr_dec;
	logic ptr_used;
	logic [3:0] fcnt_q;
	logic fbusy_q;
	logic [NUM_IRQ-1:0] flag_smp_q;
	logic bkp_pend_q, dbg_pend_q;
	logic [2:0] active_q;
	logic [15:0] vec_base;
	cav_win_t win;
	logic take;
	logic [7:0] rd_mux;

	// Mode decode: upper mode bit alone selects wide addressing
	assign wide = amode_q[CAV_AM_WIDE_BIT];
	assign WIDE_MODE_O = wide;
	assign sel = psel_q[CAV_PS_SEL_BIT];

	// Ticket sequencer; any touch of the ticket register voids an open ticket
	always_ff @(posedge REF_CLK_I) begin
		if (RST_I) begin
			tk_q <= CAV_TK_IDLE;
		end else if (SFR_WR_I && SFR_ADDR_I == CAV_OFS_TICKET) begin
			if (SFR_WDATA_I == CAV_TICKET_FIRST) begin
				tk_q <= CAV_TK_ARMED;
			end else if (SFR_WDATA_I == CAV_TICKET_SECOND && tk_q == CAV_TK_ARMED) begin
				tk_q <= CAV_TK_OPEN;
			end else begin
				tk_q <= CAV_TK_IDLE;
			end
		end else if (SFR_RD_I && SFR_ADDR_I == CAV_OFS_TICKET) begin
			tk_q <= CAV_TK_IDLE;
		end else if (prot_ok) begin
			tk_q <= CAV_TK_IDLE;
		end
	end

	// A protected write is honoured only with an open ticket, which it then spends
	assign prot_ok = SFR_WR_I && tk_q == CAV_TK_OPEN
		&& (SFR_ADDR_I == CAV_OFS_AMODE || SFR_ADDR_I == CAV_OFS_XBASE);

	// Protected mode and relocation registers; the stack flag bit is not writable
	always_ff @(posedge REF_CLK_I) begin
		if (RST_I) begin
			amode_q <= CAV_RST_ZERO;
			xbase_q <= CAV_RST_ZERO;
		end else if (prot_ok) begin
			if (SFR_ADDR_I == CAV_OFS_AMODE) begin
				amode_q <= SFR_WDATA_I & ~(8'h01 << CAV_AM_XSTACK_BIT);
			end else begin
				xbase_q <= SFR_WDATA_I;
			end
		end
	end

	// Plain control registers
	always_ff @(posedge REF_CLK_I) begin
		if (RST_I) begin
			wait_q <= CAV_RST_WAIT;
			ri_page_q <= CAV_RST_ZERO;
			ri_top_q <= CAV_RST_ZERO;
		end else if (SFR_WR_I) begin
			case (SFR_ADDR_I)
				CAV_OFS_WAIT: wait_q <= SFR_WDATA_I[3:0];
				CAV_OFS_RI_PAGE: ri_page_q <= SFR_WDATA_I;
				CAV_OFS_RI_TOP: ri_top_q <= SFR_WDATA_I;
				default: ;
			endcase
		end
	end

	// Stack pointer: wide mode carries into the high byte, compatible stays in 8 bits
	assign sp_full = wide ? {sp_high_q, sp_low_q} : {8'h00, sp_low_q};
	assign wr_sp_low = SFR_WR_I && SFR_ADDR_I == CAV_OFS_SP_LOW;
	assign wr_sp_high = SFR_WR_I && SFR_ADDR_I == CAV_OFS_SP_HIGH;
	always_comb begin
		sp_next = sp_full;
		if (PUSH_I) begin
			sp_next = sp_full + 16'h0001;
		end else if (POP_I) begin
			sp_next = sp_full - 16'h0001;
		end
	end

	// Stack bytes; a push or pop in the same cycle outranks a bus write
	always_ff @(posedge REF_CLK_I) begin
		if (RST_I) begin
			sp_low_q <= CAV_RST_ZERO;
			sp_high_q <= CAV_RST_ZERO;
		end else if (PUSH_I || POP_I) begin
			sp_low_q <= sp_next[7:0];
			if (wide) begin
				sp_high_q <= sp_next[15:8];
			end
		end else begin
			if (wr_sp_low) begin
				sp_low_q <= SFR_WDATA_I;
			end
			if (wr_sp_high) begin
				sp_high_q <= SFR_WDATA_I;
			end
		end
	end

	// Stack RAM request, registered; push writes at the incremented address
	always_ff @(posedge REF_CLK_I) begin
		if (RST_I) begin
			STK_O <= '0;
		end else begin
			STK_O.we <= PUSH_I;
			STK_O.re <= POP_I && !PUSH_I;
			STK_O.wdata <= ACC_I;
			STK_O.addr <= PUSH_I ? sp_next : sp_full;
		end
	end

	// Pointer stepping: direction bit chosen by the selected pointer
	assign ptr_cur = sel ? ptr1_q : ptr0_q;
	assign ptr_dec = sel ? psel_q[CAV_PS_DIR1_BIT] : psel_q[CAV_PS_DIR0_BIT];
	assign ptr_used = PTR_INC_I | PTR_USE_I | MOVX_DP_I;

	cav_ptr_step u_step (
		.ptr_i(ptr_cur),
		.dec_i(ptr_dec),
		.wide_i(wide),
		.ptr_o(ptr_stepped)
	);

	// Pointer bytes; an executed step outranks a same-cycle bus write
	always_ff @(posedge REF_CLK_I) begin
		if (RST_I) begin
			ptr0_q <= 24'h000000;
			ptr1_q <= 24'h000000;
		end else if (PTR_INC_I) begin
			if (sel) begin
				ptr1_q <= ptr_stepped;
			end else begin
				ptr0_q <= ptr_stepped;
			end
		end else if (SFR_WR_I) begin
			case (SFR_ADDR_I)
				CAV_OFS_P0_LOW: ptr0_q[7:0] <= SFR_WDATA_I;
				CAV_OFS_P0_HIGH: ptr0_q[15:8] <= SFR_WDATA_I;
				CAV_OFS_P0_TOP: ptr0_q[23:16] <= SFR_WDATA_I;
				CAV_OFS_P1_LOW: ptr1_q[7:0] <= SFR_WDATA_I;
				CAV_OFS_P1_HIGH: ptr1_q[15:8] <= SFR_WDATA_I;
				CAV_OFS_P1_TOP: ptr1_q[23:16] <= SFR_WDATA_I;
				default: ;
			endcase
		end
	end

	// Selection register; hardware toggling wins over a bus write of the same cycle
	always_ff @(posedge REF_CLK_I) begin
		if (RST_I) begin
			psel_q <= CAV_RST_ZERO;
		end else begin
			if (SFR_WR_I && SFR_ADDR_I == CAV_OFS_PSEL) begin
				psel_q <= SFR_WDATA_I & 8'he1;
			end
			if (ptr_used && psel_q[CAV_PS_TOGGLE_BIT]) begin
				psel_q[CAV_PS_SEL_BIT] <= ~sel;
			end
		end
	end

	// External data address, registered with a one-cycle valid
	always_ff @(posedge REF_CLK_I) begin
		if (RST_I) begin
			XADDR_O <= 24'h000000;
			XADDR_VLD_O <= 1'b0;
		end else begin
			XADDR_VLD_O <= MOVX_RI_I | MOVX_DP_I;
			if (MOVX_RI_I) begin
				XADDR_O <= {ri_top_q,
					amode_q[CAV_AM_RIPAGE_BIT] ? ri_page_q : P2_LATCH_I, RI_I};
			end else if (MOVX_DP_I) begin
				XADDR_O <= ptr_cur;
			end
		end
	end

	// Fetch wait counter; requests while busy are ignored
	always_ff @(posedge REF_CLK_I) begin
		if (RST_I) begin
			fbusy_q <= 1'b0;
			fcnt_q <= 4'h0;
			FLASH_ADDR_O <= 20'h00000;
		end else if (!fbusy_q && FETCH_REQ_I) begin
			fbusy_q <= 1'b1;
			fcnt_q <= wait_q;
			FLASH_ADDR_O <= wide ? FETCH_ADDR_I : {4'h0, FETCH_ADDR_I[15:0]};
		end else if (fbusy_q) begin
			if (fcnt_q == 4'h0) begin
				fbusy_q <= 1'b0;
			end else begin
				fcnt_q <= fcnt_q - 4'h1;
			end
		end
	end
	assign FETCH_DONE_O = fbusy_q && fcnt_q == 4'h0;

	// Request sampling on every edge ahead of arbitration
	always_ff @(posedge REF_CLK_I) begin
		if (RST_I) begin
			flag_smp_q <= '0;
		end else begin
			flag_smp_q <= IRQ_FLAG_I;
		end
	end

	// Debug-class pending bits; a new event in the clearing cycle survives
	always_ff @(posedge REF_CLK_I) begin
		if (RST_I) begin
			bkp_pend_q <= 1'b0;
			dbg_pend_q <= 1'b0;
		end else begin
			if (BKPT_MATCH_I) begin
				bkp_pend_q <= 1'b1;
			end else if (take && win.breakpoint_irq) begin
				bkp_pend_q <= 1'b0;
			end
			if (DBG_MATCH_I && DBG_PORT_MODE_I) begin
				dbg_pend_q <= 1'b1;
			end else if (take && win.dbg) begin
				dbg_pend_q <= 1'b0;
			end
		end
	end

	// Relocated vectors sit in the top 4KB of flash
	assign vec_base = amode_q[CAV_AM_RELOC_BIT] ? {TOP_NIBBLE, 12'h000} : 16'h0000;

	cav_irq_arb #(
		.NUM(NUM_IRQ)
	) u_arb (
		.pend_i(flag_smp_q),
		.en_i(IRQ_EN_I),
		.high_i(IRQ_HIGH_I),
		.global_en_i(GLOBAL_EN_I),
		.bkp_i(bkp_pend_q),
		.dbg_i(dbg_pend_q),
		.active_i(active_q),
		.base_i(vec_base),
		.win_o(win)
	);

	assign IRQ_REQ_O = win.valid;
	assign IRQ_VEC_O = win.vec;
	assign take = IRQ_ACK_I && win.valid;

	// Service nesting; return retires the highest active level first
	always_ff @(posedge REF_CLK_I) begin
		if (RST_I) begin
			active_q <= 3'b000;
		end else if (take) begin
			active_q <= active_q | win.level;
		end else if (RETI_I) begin
			if (active_q[2]) begin
				active_q[2] <= 1'b0;
			end else if (active_q[1]) begin
				active_q[1] <= 1'b0;
			end else begin
				active_q[0] <= 1'b0;
			end
		end
	end

	// Timer flags are cleared by hardware when their vector is taken
	always_ff @(posedge REF_CLK_I) begin
		if (RST_I) begin
			TIMER_CLR_O <= 2'b00;
		end else begin
			TIMER_CLR_O[0] <= take && !win.level[2] && win.idx == 4'(CAV_IRQ_TIMER0);
			TIMER_CLR_O[1] <= take && !win.level[2] && win.idx == 4'(CAV_IRQ_TIMER1);
		end
	end

	// Read mux; unmapped offsets read zero
	always_comb begin
		case (SFR_ADDR_I)
			CAV_OFS_SP_LOW: rd_mux = sp_low_q;
			CAV_OFS_SP_HIGH: rd_mux = sp_high_q;
			CAV_OFS_P0_LOW: rd_mux = ptr0_q[7:0];
			CAV_OFS_P0_HIGH: rd_mux = ptr0_q[15:8];
			CAV_OFS_P0_TOP: rd_mux = ptr0_q[23:16];
			CAV_OFS_P1_LOW: rd_mux = ptr1_q[7:0];
			CAV_OFS_P1_HIGH: rd_mux = ptr1_q[15:8];
			CAV_OFS_P1_TOP: rd_mux = ptr1_q[23:16];
			CAV_OFS_PSEL: rd_mux = psel_q;
			CAV_OFS_WAIT: rd_mux = {4'h0, wait_q};
			CAV_OFS_AMODE: rd_mux = amode_q | (8'(wide) << CAV_AM_XSTACK_BIT);
			CAV_OFS_STATUS: rd_mux = (8'(active_q[1] | active_q[2]) << CAV_STAT_HIGH_BIT)
				| (8'(active_q[0]) << CAV_STAT_LOW_BIT);
			CAV_OFS_XBASE: rd_mux = xbase_q;
			CAV_OFS_TICKET: rd_mux = {7'h00, tk_q == CAV_TK_OPEN};
			CAV_OFS_RI_PAGE: rd_mux = ri_page_q;
			CAV_OFS_RI_TOP: rd_mux = ri_top_q;
			default: rd_mux = 8'h00;
		endcase
	end

	// Read data registered: valid the cycle after the read strobe
	always_ff @(posedge REF_CLK_I) begin
		if (RST_I) begin
			SFR_RDATA_O <= 8'h00;
		end else if (SFR_RD_I) begin
			SFR_RDATA_O <= rd_mux;
		end
	end
endmodule
`default_nettype wire

// ---- bench/cav_core_checker.sv ----
// Purpose: Port-level checks for the addressing and vectoring core
// Assumes: Single clock domain, synchronous active-high reset
// Notes: Attached to every core instance by bind
`timescale 1ns/1ps
`default_nettype none
module cav_core_checker import cav_pkg::*; (
	input wire logic REF_CLK_I,
	input wire logic RST_I,
	input wire logic [7:0] SFR_ADDR_I,
	input wire logic SFR_WR_I,
	input wire logic SFR_RD_I,
	input wire logic [7:0] SFR_RDATA_O,
	input wire logic PUSH_I,
	input wire logic POP_I,
	input wire cav_stk_t STK_O,
	input wire logic [19:0] FLASH_ADDR_O,
	input wire logic FETCH_DONE_O,
	input wire logic MOVX_RI_I,
	input wire logic MOVX_DP_I,
	input wire logic [7:0] RI_I,
	input wire logic [23:0] XADDR_O,
	input wire logic XADDR_VLD_O,
	input wire logic GLOBAL_EN_I,
	input wire logic IRQ_ACK_I,
	input wire logic IRQ_REQ_O,
	input wire logic [15:0] IRQ_VEC_O,
	input wire logic [1:0] TIMER_CLR_O,
	input wire logic WIDE_MODE_O
);
	// One clock, one reset
	default clocking cb @(posedge REF_CLK_I);
	endclocking
	default disable iff (RST_I);

	// Stack strobes answer a cycle later
	AST_STK_PUSH: assert property (PUSH_I |=> STK_O.we)
		else $error("no stack write");
	AST_STK_POP: assert property (POP_I && !PUSH_I |=> STK_O.re && !STK_O.we)
		else $error("no stack read");
	AST_STK_COMPAT: assert property ((STK_O.we || STK_O.re) && !$past(WIDE_MODE_O) |->
		STK_O.addr[15:8] == 8'h00)
		else $error("stack above 8 bits");
	// Fetch done is one pulse
	AST_FETCH_PULSE: assert property (FETCH_DONE_O |=> !FETCH_DONE_O)
		else $error("done too long");
	AST_FETCH_COMPAT: assert property (FETCH_DONE_O && !WIDE_MODE_O |->
		FLASH_ADDR_O[19:16] == 4'h0)
		else $error("fetch above 64K");
	AST_XADDR_VLD: assert property ((MOVX_RI_I || MOVX_DP_I) |=> XADDR_VLD_O)
		else $error("no address valid");
	AST_XADDR_RI: assert property (MOVX_RI_I |=> XADDR_O[7:0] == $past(RI_I))
		else $error("low byte wrong");
	// Timer clears follow taken vectors
	AST_TIMER_CLR: assert property (IRQ_ACK_I && IRQ_REQ_O && IRQ_VEC_O[7:0] == 8'h0b |=>
		TIMER_CLR_O == 2'b01)
		else $error("no timer0 clear");
	AST_TIMER_CAUSE: assert property (TIMER_CLR_O != 2'b00 |-> $past(IRQ_ACK_I) && $past(IRQ_REQ_O))
		else $error("stray timer clear");
	AST_VEC_SHAPE: assert property (IRQ_REQ_O |-> IRQ_VEC_O[15:12] inside {4'h0, 4'hf} &&
		((IRQ_VEC_O[2:0] == 3'h3 && IRQ_VEC_O[11:7] == 5'h00) ||
		IRQ_VEC_O[11:0] inside {12'h080, 12'h0c0}))
		else $error("bad vector");
	AST_GLOBAL_OFF: assert property (!GLOBAL_EN_I && !$past(GLOBAL_EN_I) && IRQ_REQ_O |->
		IRQ_VEC_O[7:0] inside {8'h80, 8'hc0})
		else $error("masked request");
	AST_RDATA_HOLD: assert property (!SFR_RD_I |=> $stable(SFR_RDATA_O))
		else $error("read data moved");
	AST_WIDE_TICKET: assert property ($rose(WIDE_MODE_O) |->
		$past(SFR_WR_I) && $past(SFR_ADDR_I) == 8'h9d)
		else $error("stray mode change");
endmodule
bind cav_core cav_core_checker i_cav_core_checker (.*);
`default_nettype wire

// ---- bench/cav_irq_src_model.sv ----
// Purpose: Peripheral interrupt flags
// Assumes: Set and clear requests are one-cycle pulses
// Notes: A flag falls only by software clear or the timer hardware clear
`timescale 1ns/1ps
`default_nettype none
module cav_irq_src_model import cav_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [14:0] set_i,
	input wire logic [14:0] sw_clr_i,
	input wire logic [1:0] hw_clr_i,
	output logic [14:0] flag_o
);
	// Clear wins over set, so a serviced timer is never queued twice
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flag_o <= '0;
		end else begin
			flag_o <= (flag_o | set_i) & ~sw_clr_i & ~(15'(hw_clr_i[0]) << CAV_IRQ_TIMER0)
				& ~(15'(hw_clr_i[1]) << CAV_IRQ_TIMER1);
		end
	end
endmodule
`default_nettype wire

// ---- bench/tb_cav_core.sv ----
// Purpose: Bench for the addressing and vectoring core
// Assumes: Inputs change on the falling clock edge
// Notes: Expectations from register map and vector table
`timescale 1ns/1ps
`default_nettype none
module tb_cav_core import cav_pkg::*; ;
	localparam int S_PUSH = 0, S_POP = 1, S_RI = 2, S_DP = 3, S_INC = 4, S_USE = 5;
	localparam int S_ACK = 6, S_RETI = 7, S_BKP = 8, S_DBG = 9, S_FET = 10;
	logic clk, rst, wr, rd, gen, dbg_mode, xvld, req, wide, fdone;
	logic [7:0] addr, wdata, acc, ri, p2, rdata;
	logic [10:0] strb;
	logic [19:0] fa, faddr;
	logic [14:0] en, hi, set_m, clr_m, flags;
	logic [23:0] xaddr;
	logic [15:0] vec;
	logic [1:0] tclr;
	cav_stk_t stk;
	int n_mismatch, total_checks;

	cav_core i_cav_core (
		.REF_CLK_I(clk), .RST_I(rst), .SFR_ADDR_I(addr), .SFR_WR_I(wr), .SFR_RD_I(rd),
		.SFR_WDATA_I(wdata), .SFR_RDATA_O(rdata), .PUSH_I(strb[S_PUSH]), .POP_I(strb[S_POP]),
		.ACC_I(acc), .STK_O(stk), .FETCH_REQ_I(strb[S_FET]), .FETCH_ADDR_I(fa),
		.FLASH_ADDR_O(faddr), .FETCH_DONE_O(fdone), .MOVX_RI_I(strb[S_RI]),
		.MOVX_DP_I(strb[S_DP]), .RI_I(ri), .P2_LATCH_I(p2), .XADDR_O(xaddr), .XADDR_VLD_O(xvld),
		.PTR_INC_I(strb[S_INC]), .PTR_USE_I(strb[S_USE]), .IRQ_FLAG_I(flags), .IRQ_EN_I(en),
		.IRQ_HIGH_I(hi), .GLOBAL_EN_I(gen), .BKPT_MATCH_I(strb[S_BKP]),
		.DBG_PORT_MODE_I(dbg_mode), .DBG_MATCH_I(strb[S_DBG]), .IRQ_ACK_I(strb[S_ACK]),
		.RETI_I(strb[S_RETI]), .IRQ_REQ_O(req), .IRQ_VEC_O(vec), .TIMER_CLR_O(tclr),
		.WIDE_MODE_O(wide)
	);
	cav_irq_src_model i_cav_irq_src_model (
		.clk_i(clk), .rst_i(rst), .set_i(set_m), .sw_clr_i(clr_m), .hw_clr_i(tclr),
		.flag_o(flags)
	);

	// Free-running 40 MHz system clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task give_verdict();
		$display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Request flag and vector together
	task cv(input string n, input logic [16:0] e);
		chk(n, {15'h0, req, vec}, {15'h0, e});
	endtask

	// Strobe cycle, then a clear cycle so strobes never merge
	task wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
	endtask

	task rd_chk(input string n, input logic [7:0] a, input logic [7:0] e);
		@(negedge clk);
		addr = a;
		rd = 1'b1;
		@(negedge clk);
		rd = 1'b0;
		chk(n, 32'(rdata), 32'(e));
	endtask

	task strobe(input int s);
		@(negedge clk);
		strb[s] = 1'b1;
		@(negedge clk);
		strb[s] = 1'b0;
	endtask

	task amode(input logic [7:0] d);
		wr_reg(8'hc7, 8'haa);
		wr_reg(8'hc7, 8'h55);
		wr_reg(8'h9d, d);
	endtask

	// Pulse flag sets and clears, then let the sampling edge land
	task irq(input logic [14:0] s, input logic [14:0] c);
		@(negedge clk);
		set_m = s;
		clr_m = c;
		@(negedge clk);
		set_m = '0;
		clr_m = '0;
		@(negedge clk);
	endtask

	task setp(input logic s, input logic [23:0] v);
		wr_reg(s ? 8'h95 : 8'h93, v[23:16]);
		wr_reg(s ? 8'h85 : 8'h83, v[15:8]);
		wr_reg(s ? 8'h84 : 8'h82, v[7:0]);
	endtask

	task automatic t_regs();
		logic [7:0] ofs [13] = '{8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h92, 8'h93,
			8'h95, 8'h9b, 8'hc5, 8'hda, 8'hea};
		for (int i = 0; i < 13; i++) begin
			rd_chk("reset value", ofs[i], (ofs[i] == 8'h92) ? 8'h07 : 8'h00);
			wr_reg(ofs[i], 8'hff);
			rd_chk("write readback", ofs[i], ofs[i] == 8'h86 ? 8'he1 : ofs[i] == 8'h92 ? 8'h0f
				: ofs[i] == 8'hc5 ? 8'h00 : 8'hff);
			wr_reg(ofs[i], 8'h00);
		end
		wr_reg(8'hc6, 8'h01);
		rd_chk("base without ticket", 8'hc6, 8'h00);
		rd_chk("mode reset", 8'h9d, 8'h00);
	endtask

	task t_stack();
		acc = 8'h5a;
		wr_reg(8'h81, 8'h07);
		wr_reg(8'h9b, 8'h12);
		strobe(S_PUSH);
		chk("push", {7'h0, stk.we, stk.addr, stk.wdata}, {7'h0, 1'b1, 16'h0008, 8'h5a});
		rd_chk("sp after push", 8'h81, 8'h08);
		strobe(S_POP);
		chk("pop", {15'h0, stk.re, stk.addr}, {15'h0, 1'b1, 16'h0008});
		rd_chk("sp after pop", 8'h81, 8'h07);
		wr_reg(8'h9d, 8'h02);
		chk("mode no ticket", 32'(wide), 0);
		wr_reg(8'hc7, 8'haa);
		wr_reg(8'hc7, 8'h55);
		rd_chk("ticket open", 8'hc7, 8'h01);
		wr_reg(8'h9d, 8'h02);
		chk("ticket voided", 32'(wide), 0);
		amode(8'h02);
		chk("wide mode", 32'(wide), 1);
		rd_chk("stack flag", 8'h9d, 8'h06);
		wr_reg(8'h9d, 8'h00);
		chk("ticket consumed", 32'(wide), 1);
		wr_reg(8'h81, 8'hff);
		strobe(S_PUSH);
		chk("wide push", 32'(stk.addr), 32'h1300);
		rd_chk("wide sp high", 8'h9b, 8'h13);
		strobe(S_POP);
		chk("wide pop", 32'(stk.addr), 32'h1300);
		rd_chk("wide sp low", 8'h81, 8'hff);
		amode(8'h00);
		rd_chk("stack flag off", 8'h9d, 8'h00);
	endtask

	task fetch(input logic [3:0] w, input logic [19:0] exp);
		int n;
		wr_reg(8'h92, {4'h0, w});
		@(negedge clk);
		fa = 20'h51234;
		strb[S_FET] = 1'b1;
		@(negedge clk);
		strb[S_FET] = 1'b0;
		n = 1;
		while (fdone !== 1'b1 && n < 40) begin
			@(negedge clk);
			n++;
		end
		chk("access time", 32'(n), 32'(w) + 32'd1);
		chk("fetch address", 32'(faddr), 32'(exp));
	endtask

	task t_movx();
		wr_reg(8'hda, 8'h34);
		wr_reg(8'hea, 8'h56);
		p2 = 8'h77;
		ri = 8'h12;
		strobe(S_RI);
		chk("ri port page", {7'h0, xvld, xaddr}, {7'h0, 1'b1, 24'h567712});
		amode(8'h08);
		strobe(S_RI);
		chk("ri page reg", 32'(xaddr), 32'h563412);
		amode(8'h00);
		setp(1'b0, 24'h0abcde);
		setp(1'b1, 24'h010203);
		wr_reg(8'h86, 8'h01);
		strobe(S_DP);
		chk("pointer1 move", 32'(xaddr), 32'h010203);
		wr_reg(8'h86, 8'h00);
		strobe(S_DP);
		chk("pointer0 move", 32'(xaddr), 32'h0abcde);
	endtask

	task t_ptr();
		logic dec;
		for (int m = 0; m < 2; m++) begin
			amode(m[0] ? 8'h02 : 8'h00);
			for (int k = 0; k < 8; k++) begin
				setp(k[0], 24'h0a0000);
				wr_reg(8'h86, {k[2], k[1], 5'h0, k[0]});
				strobe(S_INC);
				strobe(S_DP);
				dec = k[0] ? k[2] : k[1];
				chk("pointer step", 32'(xaddr), 32'(dec ? (m[0] ? 24'h09ffff : 24'h0affff)
					: 24'h0a0001));
			end
		end
		wr_reg(8'h86, 8'h20);
		strobe(S_USE);
		rd_chk("toggle on use", 8'h86, 8'h21);
		strobe(S_DP);
		rd_chk("toggle on move", 8'h86, 8'h20);
		strobe(S_INC);
		rd_chk("toggle on step", 8'h86, 8'h21);
		wr_reg(8'h86, 8'h00);
		amode(8'h00);
	endtask

	task t_irq();
		en = '1;
		hi = 15'h0020;
		gen = 1'b1;
		for (int i = 0; i < 15; i++) begin
			irq(15'(1 << i), '0);
			cv("vector", 17'h10003 + 17'(8 * i));
			irq('0, 15'(1 << i));
		end
		irq(15'h0005, '0);
		cv("tie order", 17'h10003);
		irq(15'h0020, '0);
		cv("high first", 17'h1002b);
		gen = 1'b0;
		irq('0, '0);
		cv("global off", 17'h0);
		gen = 1'b1;
		en = 15'h7fdf;
		irq('0, '0);
		cv("source masked", 17'h10003);
		en = '1;
		irq('0, '0);
		strobe(S_ACK);
		rd_chk("high active", 8'hc5, 8'h40);
		cv("low blocked", 17'h0);
		strobe(S_RETI);
		irq('0, 15'h0020);
		strobe(S_ACK);
		rd_chk("low active", 8'hc5, 8'h20);
		irq(15'h0020, '0);
		cv("preempt", 17'h1002b);
		strobe(S_ACK);
		rd_chk("nested", 8'hc5, 8'h60);
		strobe(S_RETI);
		rd_chk("back to low", 8'hc5, 8'h20);
		strobe(S_RETI);
		irq('0, 15'h0025);
		rd_chk("idle", 8'hc5, 8'h00);
		for (int t = 0; t < 2; t++) begin
			irq(15'(2 << (2 * t)), '0);
			strobe(S_ACK);
			chk("timer clear", {30'h0, tclr}, {30'h0, t[0] ? 2'b10 : 2'b01});
			irq('0, '0);
			chk("flag gone", 32'(flags), 0);
			strobe(S_RETI);
		end
	endtask

	task t_debug();
		gen = 1'b0;
		irq(15'h0001, '0);
		strobe(S_DBG);
		irq('0, '0);
		cv("debug needs port mode", 17'h0);
		dbg_mode = 1'b1;
		strobe(S_BKP);
		irq('0, '0);
		cv("breakpoint", 17'h10080);
		strobe(S_DBG);
		irq('0, '0);
		cv("debug first", 17'h100c0);
		strobe(S_ACK);
		strobe(S_RETI);
		irq('0, '0);
		cv("breakpoint next", 17'h10080);
		strobe(S_ACK);
		strobe(S_RETI);
		irq('0, '0);
		cv("all served", 17'h0);
		amode(8'h20);
		gen = 1'b1;
		irq('0, '0);
		cv("relocated", 17'h1f003);
		strobe(S_BKP);
		irq('0, '0);
		cv("relocated breakpoint", 17'h1f080);
		strobe(S_ACK);
		strobe(S_RETI);
		irq('0, 15'h0001);
		amode(8'h00);
	endtask

	// Reset for 12 cycles, then each scenario
	initial begin
		{rst, wr, rd, gen, dbg_mode} = 5'b10000;
		{addr, wdata, acc, ri, p2} = '0;
		{strb, fa, en, hi, set_m, clr_m} = '0;
		repeat (12) @(negedge clk);
		rst = 1'b0;
		t_regs();
		t_stack();
		fetch(4'h0, 20'h01234);
		fetch(4'h3, 20'h01234);
		fetch(4'hf, 20'h01234);
		amode(8'h02);
		fetch(4'h7, 20'h51234);
		amode(8'h00);
		t_movx();
		t_ptr();
		t_irq();
		t_debug();
		give_verdict();
	end

	// Watchdog; scenarios need well under a thousand cycles
	initial begin
		#(25.0 * 30000);
		n_mismatch++;
		give_verdict();
	end
endmodule
`default_nettype wire
